/* common/bpm_params.svh */
// offsets, field positions and reset values of the pin multiplexer
`ifndef BPM_PARAMS_SVH
`define BPM_PARAMS_SVH
`define BPM_OFF_SYSCTL 12'h201
`define BPM_OFF_P1_DATA 12'h203
`define BPM_OFF_P1_DIR 12'h204
`define BPM_OFF_P2_DATA 12'h205
`define BPM_OFF_P2_DIR 12'h206
`define BPM_OFF_P3_DATA 12'h207
`define BPM_OFF_P3_DIR 12'h208
`define BPM_OFF_P4_DATA 12'h209
`define BPM_OFF_P5_MODE 12'h20a
`define BPM_OFF_P5_DIR 12'h20b
`define BPM_OFF_P5_DATA 12'h20c
`define BPM_OFF_P7_MODE 12'h20f
`define BPM_OFF_P6_DATA 12'h240
`define BPM_OFF_P6_DIR 12'h241
`define BPM_OFF_P7_DATA 12'h242
`define BPM_OFF_P7_DIR 12'h243
`define BPM_OFF_P8_DATA 12'h244
`define BPM_OFF_P8_DIR 12'h245
`define BPM_OFF_PIN_IN 12'h2a0
`define BPM_PORT_MODE_BIT 4
`define BPM_BOOT_ADDR 16'hfff9
`define BPM_RST_DATA 8'h00
`define BPM_RST_DIR 8'h00
`define BPM_RST_MODE 8'h00
`endif

/* common/bpm_pkg.sv */
// types of the pin multiplexer
package bpm_pkg;
  typedef enum logic {
    BPM_BUS_MODE,
    BPM_PORT_MODE
  } bpm_mode_t;
  typedef enum {
    BPM_BOOT_REQ,
    BPM_BOOT_WAIT,
    BPM_RUN
  } bpm_boot_t;
endpackage : bpm_pkg

/* common/bpm_pin_if.sv */
// one pin group: register value, alternate value and selection
`timescale 1ns/1ps
interface bpm_pin_if #(
  parameter int W = 8
);
  logic [W-1:0] reg_out;
  logic [W-1:0] reg_oe;
  logic [W-1:0] alt_out;
  logic [W-1:0] alt_oe;
  logic [W-1:0] alt_sel;
  logic [W-1:0] od;
  logic [W-1:0] pin_out;
  logic [W-1:0] pin_oe;
  modport ctl (output reg_out, output reg_oe, output alt_out, output alt_oe,
    output alt_sel, output od, input pin_out, input pin_oe);
  modport mux (input reg_out, input reg_oe, input alt_out, input alt_oe,
    input alt_sel, input od, output pin_out, output pin_oe);
endinterface : bpm_pin_if

/* hw/bpm_pin_sel.sv */
// selects per pin between port register and alternate function
`timescale 1ns/1ps
module bpm_pin_sel (
  bpm_pin_if.mux p
);
  wire [$bits(p.reg_out)-1:0] reg_oe_eff;
  // open drain bits only pull low
  assign reg_oe_eff = p.reg_oe & ~(p.od & p.reg_out);
  // alternate function wins, register kept aside
  assign p.pin_out = (p.alt_sel & p.alt_out) | (~p.alt_sel & p.reg_out & ~p.od);
  assign p.pin_oe = (p.alt_sel & p.alt_oe) | (~p.alt_sel & reg_oe_eff);
endmodule : bpm_pin_sel

/* hw/bpm_boot_load.sv */
// fetches the system control byte from program memory after reset
`timescale 1ns/1ps
`include "bpm_params.svh"
module bpm_boot_load (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_mem_ack,
  input wire logic [7:0] i_mem_data,
  output logic o_mem_req,
  output logic [15:0] o_mem_addr,
  output logic o_load,
  output logic [7:0] o_byte
);
  bpm_pkg::bpm_boot_t st_r;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_r <= bpm_pkg::BPM_BOOT_REQ;
      o_mem_req <= 1'b0;
      o_load <= 1'b0;
      o_byte <= 8'h00;
      o_mem_addr <= `BPM_BOOT_ADDR;
    end else begin
      o_load <= 1'b0;
      case (st_r)
        bpm_pkg::BPM_BOOT_REQ: begin
          o_mem_req <= 1'b1;
          st_r <= bpm_pkg::BPM_BOOT_WAIT;
        end
        bpm_pkg::BPM_BOOT_WAIT: begin
          if (i_mem_ack) begin
            o_mem_req <= 1'b0;
            o_load <= 1'b1;
            o_byte <= i_mem_data;
            st_r <= bpm_pkg::BPM_RUN;
          end
        end
        default: st_r <= bpm_pkg::BPM_RUN;
      endcase
    end
  end
endmodule : bpm_boot_load

/* hw/bpm_top.sv */
// pin function multiplexer with system control and port registers on apb
// What this block does
// - reset loads control byte from program memory
// - control bit 4 one selects port pins
// - control bit 4 zero selects external bus
// - port mode register bits pick alternate function
// - bus mode drives read/not-write on fourth_io_bit0
// - first port carries data bits in bus mode
// - second/third ports carry address in bus mode
// - fifth port normal mode is open drain
// - special even fifth bits are read strobes
// - special odd fifth bits are write strobes
// - special seventh bits 0..5 give bank address
// - special seventh bit 6 gives inverted read/write
// - special seventh bit 7 gives memory power-down
// - eighth_io_bit7_irq also feeds interrupt source 7
// - sixth port, eighth bits 0..3 plain
`timescale 1ns/1ps
`include "bpm_params.svh"
module bpm_top (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_boot_ack,
  input wire logic [7:0] i_boot_data,
  output logic o_boot_req,
  output logic [15:0] o_boot_addr,
  output logic o_boot_done,
  input wire logic i_cpu_ext_valid,
  input wire logic i_cpu_rnw,
  input wire logic [15:0] i_cpu_addr,
  input wire logic [7:0] i_cpu_wdata,
  output logic [7:0] o_cpu_rdata,
  input wire logic [5:0] i_bank_addr,
  input wire logic i_mem_power_down,
  input wire logic [7:0] i_first_io_in,
  input wire logic [7:0] i_second_io_in,
  input wire logic [7:0] i_third_io_in,
  input wire logic i_fourth_io_in,
  input wire logic [5:0] i_fifth_io_in,
  input wire logic [7:0] i_sixth_io_in,
  input wire logic [7:0] i_seventh_io_in,
  input wire logic [4:0] i_eighth_io_in,
  output logic [7:0] o_first_io_out,
  output logic [7:0] o_first_io_oe,
  output logic [7:0] o_second_io_out,
  output logic [7:0] o_second_io_oe,
  output logic [7:0] o_third_io_out,
  output logic [7:0] o_third_io_oe,
  output logic o_fourth_io_out,
  output logic o_fourth_io_oe,
  output logic [5:0] o_fifth_io_out,
  output logic [5:0] o_fifth_io_oe,
  output logic [7:0] o_sixth_io_out,
  output logic [7:0] o_sixth_io_oe,
  output logic [7:0] o_seventh_io_out,
  output logic [7:0] o_seventh_io_oe,
  output logic [4:0] o_eighth_io_out,
  output logic [4:0] o_eighth_io_oe,
  output logic o_irq_source7
);
  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] sysctl_r;
  logic [7:0] p1_r, p1d_r, p2_r, p2d_r, p3_r, p3d_r;
  logic p4_r, p4d_r;
  logic [5:0] p5_r, p5d_r, p5m_r;
  logic [7:0] p6_r, p6d_r, p7_r, p7d_r, p7m_r;
  logic [4:0] p8_r, p8d_r;
  logic boot_load;
  logic [7:0] boot_byte;
  bpm_boot_load u_boot (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_mem_ack(i_boot_ack),
    .i_mem_data(i_boot_data),
    .o_mem_req(o_boot_req),
    .o_mem_addr(o_boot_addr),
    .o_load(boot_load),
    .o_byte(boot_byte)
  );
  ////////////////////////////////////////////////////////////////////////
  // apb decode, one cycle access, unmapped reads zero with pslverr
  wire wr = i_psel & i_penable & i_pwrite & o_pready;
  wire rd_setup = i_psel & ~i_penable;
  wire [11:0] idx = {2'b00, i_paddr[11:2]};
  wire [7:0] wd = i_pwdata[7:0];
  logic [7:0] rsel;
  logic hit;
  always_comb begin
    hit = 1'b1;
    case (idx)
      `BPM_OFF_SYSCTL: rsel = sysctl_r;
      `BPM_OFF_P1_DATA: rsel = p1_r;
      `BPM_OFF_P1_DIR: rsel = p1d_r;
      `BPM_OFF_P2_DATA: rsel = p2_r;
      `BPM_OFF_P2_DIR: rsel = p2d_r;
      `BPM_OFF_P3_DATA: rsel = p3_r;
      `BPM_OFF_P3_DIR: rsel = p3d_r;
      `BPM_OFF_P4_DATA: rsel = {7'h00, p4_r};
      `BPM_OFF_P5_MODE: rsel = {2'h0, p5m_r};
      `BPM_OFF_P5_DIR: rsel = {2'h0, p5d_r};
      `BPM_OFF_P5_DATA: rsel = {2'h0, p5_r};
      `BPM_OFF_P7_MODE: rsel = p7m_r;
      `BPM_OFF_P6_DATA: rsel = p6_r;
      `BPM_OFF_P6_DIR: rsel = p6d_r;
      `BPM_OFF_P7_DATA: rsel = p7_r;
      `BPM_OFF_P7_DIR: rsel = p7d_r;
      `BPM_OFF_P8_DATA: rsel = {p8_r[4], 3'h0, p8_r[3:0]};
      `BPM_OFF_P8_DIR: rsel = {p8d_r[4], 3'h0, p8d_r[3:0]};
      `BPM_OFF_PIN_IN: rsel = {i_eighth_io_in[4], i_sixth_io_in[6:0]};
      default: begin
        rsel = 8'h00;
        hit = 1'b0;
      end
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= rd_setup;
      if (rd_setup) begin
        o_prdata <= {24'h0, rsel};
        o_pslverr <= ~hit;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // register writes; port data kept while alternate owns the pin
  wire wr_ok = wr & ~boot_load;
  wire we_sysctl = wr_ok & (idx == `BPM_OFF_SYSCTL);
  wire we_p1 = wr_ok & (idx == `BPM_OFF_P1_DATA);
  wire we_p1d = wr_ok & (idx == `BPM_OFF_P1_DIR);
  wire we_p2 = wr_ok & (idx == `BPM_OFF_P2_DATA);
  wire we_p2d = wr_ok & (idx == `BPM_OFF_P2_DIR);
  wire we_p3 = wr_ok & (idx == `BPM_OFF_P3_DATA);
  wire we_p3d = wr_ok & (idx == `BPM_OFF_P3_DIR);
  wire we_p4 = wr_ok & (idx == `BPM_OFF_P4_DATA);
  wire we_p5m = wr_ok & (idx == `BPM_OFF_P5_MODE);
  wire we_p5d = wr_ok & (idx == `BPM_OFF_P5_DIR);
  wire we_p5 = wr_ok & (idx == `BPM_OFF_P5_DATA);
  wire we_p7m = wr_ok & (idx == `BPM_OFF_P7_MODE);
  wire we_p6 = wr_ok & (idx == `BPM_OFF_P6_DATA);
  wire we_p6d = wr_ok & (idx == `BPM_OFF_P6_DIR);
  wire we_p7 = wr_ok & (idx == `BPM_OFF_P7_DATA);
  wire we_p7d = wr_ok & (idx == `BPM_OFF_P7_DIR);
  wire we_p8 = wr_ok & (idx == `BPM_OFF_P8_DATA);
  wire we_p8d = wr_ok & (idx == `BPM_OFF_P8_DIR);
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sysctl_r <= 8'h00;
      {p1_r, p1d_r, p2_r, p2d_r, p3_r, p3d_r} <= {6{`BPM_RST_DATA}};
      p4_r <= 1'b0;
      p4d_r <= 1'b0;
      {p5_r, p5d_r, p5m_r} <= 18'h0;
      {p6_r, p6d_r, p7_r, p7d_r} <= {4{`BPM_RST_DIR}};
      p7m_r <= `BPM_RST_MODE;
      {p8_r, p8d_r} <= 10'h0;
    end else begin
      if (boot_load) begin
        sysctl_r <= boot_byte;
      end else if (we_sysctl) begin
        sysctl_r <= wd;
      end
      if (we_p1) begin
        p1_r <= wd;
      end
      if (we_p1d) begin
        p1d_r <= wd;
      end
      if (we_p2) begin
        p2_r <= wd;
      end
      if (we_p2d) begin
        p2d_r <= wd;
      end
      if (we_p3) begin
        p3_r <= wd;
      end
      if (we_p3d) begin
        p3d_r <= wd;
      end
      if (we_p4) begin
        p4_r <= wd[0];
      end
      if (we_p5m) begin
        p5m_r <= wd[5:0];
      end
      if (we_p5d) begin
        p5d_r <= wd[5:0];
      end
      if (we_p5) begin
        p5_r <= wd[5:0];
      end
      if (we_p7m) begin
        p7m_r <= wd;
      end
      if (we_p6) begin
        p6_r <= wd;
      end
      if (we_p6d) begin
        p6d_r <= wd;
      end
      if (we_p7) begin
        p7_r <= wd;
      end
      if (we_p7d) begin
        p7d_r <= wd;
      end
      // software bit 7 is the interrupt-capable pin
      if (we_p8) begin
        p8_r <= {wd[7], wd[3:0]};
      end
      if (we_p8d) begin
        p8d_r <= {wd[7], wd[3:0]};
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // mode and alternate functions
  bpm_pkg::bpm_mode_t mode;
  assign mode = bpm_pkg::bpm_mode_t'(sysctl_r[`BPM_PORT_MODE_BIT]);
  wire bus_en = (mode == bpm_pkg::BPM_BUS_MODE);
  wire ext_rd = i_cpu_ext_valid & i_cpu_rnw;
  wire ext_wr = i_cpu_ext_valid & ~i_cpu_rnw;
  wire [2:0] strb_hit;
  // strobe selects by external address window, one per strobe pair
  assign strb_hit[0] = i_cpu_ext_valid & (i_cpu_addr[15:14] == 2'b01);
  assign strb_hit[1] = i_cpu_ext_valid & (i_cpu_addr[15:14] == 2'b10);
  assign strb_hit[2] = i_cpu_ext_valid & (i_cpu_addr[15:14] == 2'b11);
  wire [5:0] strobe_n;
  genvar g;
  for (g = 0; g < 3; g++) begin : g_strb
    assign strobe_n[2*g] = ~(strb_hit[g] & i_cpu_rnw);
    assign strobe_n[2*g+1] = ~(strb_hit[g] & ~i_cpu_rnw);
  end
  bpm_pin_if #(.W(8)) pf1 ();
  bpm_pin_if #(.W(8)) pf2 ();
  bpm_pin_if #(.W(8)) pf3 ();
  bpm_pin_if #(.W(1)) pf4 ();
  bpm_pin_if #(.W(6)) pf5 ();
  bpm_pin_if #(.W(8)) pf7 ();
  assign pf1.reg_out = p1_r;
  assign pf1.reg_oe = p1d_r;
  assign pf1.alt_out = i_cpu_wdata;
  assign pf1.alt_oe = {8{ext_wr}};
  assign pf1.alt_sel = {8{bus_en}};
  assign pf1.od = 8'h00;
  assign pf2.reg_out = p2_r;
  assign pf2.reg_oe = p2d_r;
  assign pf2.alt_out = i_cpu_addr[7:0];
  assign pf2.alt_oe = 8'hff;
  assign pf2.alt_sel = {8{bus_en}};
  assign pf2.od = 8'h00;
  assign pf3.reg_out = p3_r;
  assign pf3.reg_oe = p3d_r;
  assign pf3.alt_out = i_cpu_addr[15:8];
  assign pf3.alt_oe = 8'hff;
  assign pf3.alt_sel = {8{bus_en}};
  assign pf3.od = 8'h00;
  assign pf4.reg_out = p4_r;
  assign pf4.reg_oe = p4d_r;
  assign pf4.alt_out = i_cpu_rnw | ~i_cpu_ext_valid;
  assign pf4.alt_oe = 1'b1;
  assign pf4.alt_sel = bus_en;
  assign pf4.od = 1'b0;
  assign pf5.reg_out = p5_r;
  assign pf5.reg_oe = p5d_r;
  assign pf5.alt_out = strobe_n;
  assign pf5.alt_oe = 6'h3f;
  assign pf5.alt_sel = p5m_r;
  assign pf5.od = 6'h3f;
  assign pf7.reg_out = p7_r;
  assign pf7.reg_oe = p7d_r;
  // bank address, inverted read/write, power-down
  assign pf7.alt_out = {i_mem_power_down, ~(i_cpu_rnw | ~i_cpu_ext_valid), i_bank_addr};
  assign pf7.alt_oe = 8'hff;
  assign pf7.alt_sel = p7m_r;
  assign pf7.od = 8'h00;
  bpm_pin_sel u_s1 (.p(pf1.mux));
  bpm_pin_sel u_s2 (.p(pf2.mux));
  bpm_pin_sel u_s3 (.p(pf3.mux));
  bpm_pin_sel u_s4 (.p(pf4.mux));
  bpm_pin_sel u_s5 (.p(pf5.mux));
  bpm_pin_sel u_s7 (.p(pf7.mux));
  ////////////////////////////////////////////////////////////////////////
  // registered pin outputs
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_first_io_out <= 8'h00;
      o_first_io_oe <= 8'h00;
      o_second_io_out <= 8'h00;
      o_second_io_oe <= 8'h00;
      o_third_io_out <= 8'h00;
      o_third_io_oe <= 8'h00;
      o_fourth_io_out <= 1'b0;
      o_fourth_io_oe <= 1'b0;
      o_fifth_io_out <= 6'h00;
      o_fifth_io_oe <= 6'h00;
      o_sixth_io_out <= 8'h00;
      o_sixth_io_oe <= 8'h00;
      o_seventh_io_out <= 8'h00;
      o_seventh_io_oe <= 8'h00;
      o_eighth_io_out <= 5'h00;
      o_eighth_io_oe <= 5'h00;
      o_irq_source7 <= 1'b0;
      o_cpu_rdata <= 8'h00;
      o_boot_done <= 1'b0;
    end else begin
      o_first_io_out <= pf1.pin_out;
      o_first_io_oe <= pf1.pin_oe;
      o_second_io_out <= pf2.pin_out;
      o_second_io_oe <= pf2.pin_oe;
      o_third_io_out <= pf3.pin_out;
      o_third_io_oe <= pf3.pin_oe;
      o_fourth_io_out <= pf4.pin_out;
      o_fourth_io_oe <= pf4.pin_oe;
      o_fifth_io_out <= pf5.pin_out;
      o_fifth_io_oe <= pf5.pin_oe;
      o_sixth_io_out <= p6_r;
      o_sixth_io_oe <= p6d_r;
      o_seventh_io_out <= pf7.pin_out;
      o_seventh_io_oe <= pf7.pin_oe;
      o_eighth_io_out <= p8_r;
      o_eighth_io_oe <= p8d_r;
      o_irq_source7 <= i_eighth_io_in[4];
      if (ext_rd & bus_en) begin
        o_cpu_rdata <= i_first_io_in;
      end
      if (boot_load) begin
        o_boot_done <= 1'b1;
      end
    end
  end
endmodule : bpm_top

/* dv/bpm_ext_mem.sv */
// boot program memory and external data latch model
`timescale 1ns/1ps
module bpm_ext_mem #(
  parameter int DLY = 2,
  parameter logic [7:0] BOOT = 8'hf0
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_req,
  output logic o_ack,
  output logic [7:0] o_byte,
  input wire logic i_rnw_line,
  input wire logic [7:0] i_data_out,
  input wire logic [7:0] i_data_oe,
  output logic [7:0] o_data_in
);
  int cnt;
  logic served;
  logic [7:0] mem_r;
  always_ff @(posedge i_clk) begin
    o_ack <= 1'h0;
    if (i_reset || !i_req) begin
      cnt <= 0;
      served <= 1'h0;
    end else if (!served && cnt == DLY) begin
      o_ack <= 1'h1;
      served <= 1'h1;
    end else begin
      cnt <= cnt + 1;
    end
    if (!i_rnw_line && i_data_oe == 8'hff) begin
      mem_r <= i_data_out;
    end
  end
  assign o_byte = o_ack ? BOOT : ~BOOT;
  // with the read line low the data lines show the inverse of the driven byte, latched byte driven while the read line is high
  assign o_data_in = i_rnw_line ? mem_r : ~i_data_out;
endmodule : bpm_ext_mem

/* dv/bpm_top_asserts.sv */
// port assertions of the pin multiplexer
`timescale 1ns/1ps
module bpm_top_asserts (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic i_boot_ack,
  input wire logic [7:0] i_boot_data,
  input wire logic o_boot_req,
  input wire logic o_boot_done,
  input wire logic i_cpu_ext_valid,
  input wire logic i_cpu_rnw,
  input wire logic [15:0] i_cpu_addr,
  input wire logic [5:0] i_bank_addr,
  input wire logic i_mem_power_down,
  input wire logic [4:0] i_eighth_io_in,
  input wire logic [7:0] o_second_io_out,
  input wire logic [7:0] o_third_io_out,
  input wire logic o_fourth_io_out,
  input wire logic [5:0] o_fifth_io_out,
  input wire logic [7:0] o_seventh_io_out,
  input wire logic o_irq_source7
);
  logic mode_r, wr, rd1, wr1;
  logic [5:0] p5m_r;
  logic [7:0] p7m_r;
  assign wr = i_psel && i_penable && o_pready && i_pwrite;
  assign rd1 = i_cpu_ext_valid && i_cpu_rnw && i_cpu_addr[15:14] == 2'h1;
  assign wr1 = i_cpu_ext_valid && !i_cpu_rnw && i_cpu_addr[15:14] == 2'h1;
  ////////////////////////////////////////
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mode_r <= 1'h0;
      p5m_r <= 6'h00;
      p7m_r <= 8'h00;
    end else begin
      if (o_boot_req && i_boot_ack)
        mode_r <= i_boot_data[4];
      else if (wr && i_paddr == 12'h804)
        mode_r <= i_pwdata[4];
      if (wr && i_paddr == 12'h828)
        p5m_r <= i_pwdata[5:0];
      if (wr && i_paddr == 12'h83c)
        p7m_r <= i_pwdata[7:0];
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  property p_boot; o_boot_req && i_boot_ack |-> ##[1:2] o_boot_done; endproperty
  a_boot: assert property (p_boot) else $error("boot byte not loaded");
  property p_addr;
    !mode_r && i_cpu_ext_valid |=> {o_third_io_out, o_second_io_out} == $past(i_cpu_addr);
  endproperty
  a_addr: assert property (p_addr) else $error("bus address wrong");
  property p_rnw; !mode_r && i_cpu_ext_valid |=> o_fourth_io_out == $past(i_cpu_rnw); endproperty
  a_rnw: assert property (p_rnw) else $error("read line wrong");
  property p_od; 1'h1 |=> (o_fifth_io_out & ~$past(p5m_r)) == 6'h00; endproperty
  a_od: assert property (p_od) else $error("open drain drives high");
  property p_rds; p5m_r[0] |=> o_fifth_io_out[0] != $past(rd1); endproperty
  a_rds: assert property (p_rds) else $error("read strobe wrong");
  property p_wrs; p5m_r[1] |=> o_fifth_io_out[1] != $past(wr1); endproperty
  a_wrs: assert property (p_wrs) else $error("write strobe wrong");
  property p_bank; p7m_r[5:0] == 6'h3f |=> o_seventh_io_out[5:0] == $past(i_bank_addr); endproperty
  a_bank: assert property (p_bank) else $error("bank address wrong");
  property p_inv; p7m_r[6] && i_cpu_ext_valid |=> o_seventh_io_out[6] != $past(i_cpu_rnw); endproperty
  a_inv: assert property (p_inv) else $error("inverted read line wrong");
  property p_pdn; p7m_r[7] |=> o_seventh_io_out[7] == $past(i_mem_power_down); endproperty
  a_pdn: assert property (p_pdn) else $error("power-down wrong");
  property p_irq; 1'h1 |=> {o_irq_source7, 4'h0} == ($past(i_eighth_io_in) & 5'h10); endproperty
  a_irq: assert property (p_irq) else $error("interrupt source wrong");
  c_boot: cover property (o_boot_req && i_boot_ack);
  c_strobe: cover property (p5m_r[0] && rd1);
  c_pdn: cover property (p7m_r[7] && i_mem_power_down);
endmodule : bpm_top_asserts

/* dv/bus_port_pin_mux_test.sv */
// self-checking testbench of the pin multiplexer
`timescale 1ns/1ps
`include "bpm_params.svh"
module bus_port_pin_mux_test;
  logic i_clk, i_reset, i_psel, i_penable, i_pwrite, i_boot_ack, i_cpu_ext_valid, i_cpu_rnw;
  logic i_mem_power_down, i_fourth_io_in, o_pready, o_pslverr, o_boot_req, o_boot_done;
  logic o_fourth_io_out, o_fourth_io_oe, o_irq_source7, err;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [15:0] i_cpu_addr, o_boot_addr;
  logic [7:0] i_boot_data, i_cpu_wdata, o_cpu_rdata, i_first_io_in, i_second_io_in;
  logic [7:0] i_third_io_in, i_sixth_io_in, i_seventh_io_in, o_first_io_out, o_first_io_oe;
  logic [7:0] o_second_io_out, o_second_io_oe, o_third_io_out, o_third_io_oe, o_sixth_io_out;
  logic [7:0] o_sixth_io_oe, o_seventh_io_out, o_seventh_io_oe;
  logic [5:0] i_bank_addr, i_fifth_io_in, o_fifth_io_out, o_fifth_io_oe;
  logic [4:0] i_eighth_io_in, o_eighth_io_out, o_eighth_io_oe;
  int n_fail, compares, cyc;
  bpm_top u_dut (.i_clk, .i_reset, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_boot_ack, .i_boot_data, .o_boot_req, .o_boot_addr,
    .o_boot_done, .i_cpu_ext_valid, .i_cpu_rnw, .i_cpu_addr, .i_cpu_wdata, .o_cpu_rdata,
    .i_bank_addr, .i_mem_power_down, .i_first_io_in, .i_second_io_in, .i_third_io_in,
    .i_fourth_io_in, .i_fifth_io_in, .i_sixth_io_in, .i_seventh_io_in, .i_eighth_io_in,
    .o_first_io_out, .o_first_io_oe, .o_second_io_out, .o_second_io_oe, .o_third_io_out,
    .o_third_io_oe, .o_fourth_io_out, .o_fourth_io_oe, .o_fifth_io_out, .o_fifth_io_oe,
    .o_sixth_io_out, .o_sixth_io_oe, .o_seventh_io_out, .o_seventh_io_oe, .o_eighth_io_out,
    .o_eighth_io_oe, .o_irq_source7);
  bpm_ext_mem #(.DLY(2), .BOOT(8'hf0)) u_mem (.i_clk, .i_reset, .i_req(o_boot_req),
    .o_ack(i_boot_ack), .o_byte(i_boot_data), .i_rnw_line(o_fourth_io_out),
    .i_data_out(o_first_io_out), .i_data_oe(o_first_io_oe), .o_data_in(i_first_io_in));
  ////////////////////////////////////////
  task automatic end_sim();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input int idx, input logic [7:0] wd);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= 12'(idx * 4);
    i_pwdata <= {24'h0, wd};
    @(posedge i_clk);
    i_penable <= 1'h1;
    @(posedge i_clk);
    while (o_pready !== 1'h1)
      @(posedge i_clk);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    @(posedge i_clk);
  endtask : apb
  task automatic cpu(input logic v, input logic r, input logic [15:0] a, input logic [7:0] d);
    i_cpu_ext_valid <= v;
    i_cpu_rnw <= r;
    i_cpu_addr <= a;
    i_cpu_wdata <= d;
    repeat (3) @(posedge i_clk);
  endtask : cpu
  ////////////////////////////////////////
  task automatic t_port();
    while (o_boot_done !== 1'h1)
      @(posedge i_clk);
    chk(o_boot_addr, 16'hfff9);
    apb(1'h0, `BPM_OFF_SYSCTL, 8'h00);
    chk(rd, 32'hf0);
    apb(1'h1, `BPM_OFF_P1_DATA, 8'ha5);
    apb(1'h1, `BPM_OFF_P2_DATA, 8'h3c);
    apb(1'h1, `BPM_OFF_P3_DATA, 8'hc3);
    apb(1'h1, `BPM_OFF_P4_DATA, 8'h01);
    cpu(1'h1, 1'h0, 16'h5a3c, 8'h96);
    chk({o_fourth_io_out, o_third_io_out, o_second_io_out, o_first_io_out}, 25'h1c33ca5);
    $display("port mode test done");
  endtask : t_port
  task automatic t_bus();
    apb(1'h1, `BPM_OFF_SYSCTL, 8'he0);
    cpu(1'h1, 1'h0, 16'h5a3c, 8'h96);
    chk({o_first_io_oe, o_first_io_out}, 16'hff96);
    chk({o_fourth_io_out, o_third_io_out, o_second_io_out}, 17'h05a3c);
    chk({o_fourth_io_oe, o_third_io_oe, o_second_io_oe}, 17'h1ffff);
    cpu(1'h1, 1'h1, 16'h0001, 8'h00);
    chk({o_fourth_io_out, o_third_io_out, o_second_io_out}, 17'h10001);
    chk(o_cpu_rdata, 8'h96);
    chk(o_first_io_oe, 8'h00);
    apb(1'h0, `BPM_OFF_P1_DATA, 8'h00);
    chk(rd, 32'ha5);
    apb(1'h1, `BPM_OFF_SYSCTL, 8'hf0);
    cpu(1'h0, 1'h1, 16'h0000, 8'h00);
    chk(o_first_io_out, 8'ha5);
    $display("bus mode test done");
  endtask : t_bus
  task automatic t_fifth();
    apb(1'h1, `BPM_OFF_P5_DIR, 8'h3f);
    apb(1'h1, `BPM_OFF_P5_DATA, 8'h00);
    cpu(1'h0, 1'h1, 16'h0000, 8'h00);
    chk({o_fifth_io_oe, o_fifth_io_out}, 12'hfc0);
    apb(1'h1, `BPM_OFF_P5_DATA, 8'h3f);
    cpu(1'h0, 1'h1, 16'h0000, 8'h00);
    chk({o_fifth_io_oe, o_fifth_io_out}, 12'h000);
    apb(1'h1, `BPM_OFF_P5_MODE, 8'h3f);
    for (int k = 0; k < 6; k++) begin
      cpu(1'h1, k[0] == 1'h0, {k[2:1] + 2'h1, 14'h0}, 8'h00);
      chk(o_fifth_io_out, 6'h3f ^ (6'h01 << k));
    end
    cpu(1'h0, 1'h1, 16'h0000, 8'h00);
    chk(o_fifth_io_out, 6'h3f);
    $display("fifth port test done");
  endtask : t_fifth
  task automatic t_seventh();
    apb(1'h1, `BPM_OFF_P7_DATA, 8'h55);
    i_bank_addr <= 6'h2d;
    i_mem_power_down <= 1'h1;
    cpu(1'h1, 1'h1, 16'h0000, 8'h00);
    chk(o_seventh_io_out, 8'h55);
    apb(1'h1, `BPM_OFF_P7_MODE, 8'hff);
    cpu(1'h1, 1'h1, 16'h0000, 8'h00);
    chk(o_seventh_io_out, 8'had);
    chk(o_seventh_io_oe, 8'hff);
    cpu(1'h1, 1'h0, 16'h0000, 8'h00);
    chk(o_seventh_io_out, 8'hed);
    apb(1'h1, `BPM_OFF_P7_MODE, 8'h80);
    cpu(1'h0, 1'h1, 16'h0000, 8'h00);
    chk(o_seventh_io_out, 8'hd5);
    $display("seventh port test done");
  endtask : t_seventh
  task automatic t_misc();
    apb(1'h1, `BPM_OFF_P6_DATA, 8'h5a);
    apb(1'h1, `BPM_OFF_P8_DATA, 8'h8f);
    apb(1'h1, `BPM_OFF_P6_DIR, 8'hc3);
    apb(1'h1, `BPM_OFF_P8_DIR, 8'h81);
    i_sixth_io_in <= 8'h35;
    i_eighth_io_in <= 5'h10;
    cpu(1'h0, 1'h1, 16'h0000, 8'h00);
    chk({o_irq_source7, o_eighth_io_out, o_sixth_io_out}, 14'h3f5a);
    chk({o_eighth_io_oe, o_sixth_io_oe}, 13'h11c3);
    apb(1'h0, `BPM_OFF_P8_DATA, 8'h00);
    chk(rd, 32'h8f);
    apb(1'h0, `BPM_OFF_PIN_IN, 8'h00);
    chk(rd, 32'hb5);
    apb(1'h0, 1, 8'h00);
    chk({err, rd}, {1'h1, 32'h0});
    $display("plain port test done");
  endtask : t_misc
  ////////////////////////////////////////
  initial begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    i_reset = 1'h1;
    {i_psel, i_penable, i_pwrite, i_cpu_ext_valid, i_cpu_rnw, i_mem_power_down} = '0;
    {i_paddr, i_pwdata, i_cpu_addr, i_cpu_wdata, i_bank_addr, i_fourth_io_in} = '0;
    {i_second_io_in, i_third_io_in, i_fifth_io_in, i_sixth_io_in, i_seventh_io_in} = '0;
    i_eighth_io_in = 5'h00;
    repeat (5) @(posedge i_clk);
    i_reset <= 1'h0;
    @(posedge i_clk);
    t_port();
    t_bus();
    t_fifth();
    t_seventh();
    t_misc();
    end_sim();
  end
endmodule : bus_port_pin_mux_test
bind bpm_top bpm_top_asserts u_chk (.i_clk, .i_reset, .i_psel, .i_penable, .i_pwrite,
  .i_paddr, .i_pwdata, .o_pready, .i_boot_ack, .i_boot_data, .o_boot_req, .o_boot_done,
  .i_cpu_ext_valid, .i_cpu_rnw, .i_cpu_addr, .i_bank_addr, .i_mem_power_down,
  .i_eighth_io_in, .o_second_io_out, .o_third_io_out, .o_fourth_io_out, .o_fifth_io_out,
  .o_seventh_io_out, .o_irq_source7);
